//--- verilog/timer0_prescaler_irq_flags.sv
// Timer0 prescaler, external clock, control bits and interrupt flags
//
// Behaviour
// R1: Compare-B request needs enable, global, flag
// R2: Compare-A request needs enable, global, flag
// R3: Overflow request needs enable, global, flag
// R4: Flag bits 7 and 0 read zero
// R5: Compare-A match sets flag bit 4
// R6: Compare-B match sets flag bit 3
// R7: Overflow sets bit 1 per waveform mode
// R8: Vector execution clears its flag
// R9: Writing one clears flag, zero keeps
// R10: Select 1 direct, selects 2..5 taps 8..1024
// R11: Prescaler runs free of clock select
// R12: First prescaled count within 1..N+1 cycles
// R13: Pin latched then registered before edges
// R14: Select 7 rising, select 6 falling edges
// R15: Counter updates 2.5..3.5 cycles after edge
// R16: Pin stable around enabling external clock
// R17: External clock below half system clock
// R18: External edges bypass the prescaler
// R19: Sync mode keeps prescaler reset asserted
// R20: Clearing sync mode clears prescaler reset
// R21: Prescaler reset bit self-clears normally
// R22: Select zero stops counting
// R23: Other-timer control bits held, no effect
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`include "timer0_defs.svh"

module timer0_prescaler_irq_flags
    import timer0_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       GLOBAL_IRQ_EN,
    input  wire logic       CMP_A_MATCH,
    input  wire logic       CMP_B_MATCH,
    input  wire logic       AT_MAX,
    input  wire logic       AT_TOP,
    input  wire logic       AT_BOTTOM,
    input  wire logic       CMP_A_ACK,
    input  wire logic       CMP_B_ACK,
    input  wire logic       OVF_ACK,
    input  wire logic       EXT_COUNT_PIN,
    output logic            COUNT_TICK,
    output logic [2:0]      WAVEFORM_MODE,
    output logic            CMP_A_IRQ,
    output logic            CMP_B_IRQ,
    output logic            OVF_IRQ
);

    // =========================================================
    // Register bus decode
    reg_req_t req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    wire wr_mask  = req.wr && (req.addr == `OFS_IRQ_MASK);
    wire wr_flags = req.wr && (req.addr == `OFS_IRQ_FLAGS);
    wire wr_gtc   = req.wr && (req.addr == `OFS_GEN_CTRL);
    wire wr_tctl  = req.wr && (req.addr == `OFS_TMR_CTRL);

    // =========================================================
    // Control registers
    logic [7:0]    mask_reg;
    logic [7:0]    gtc_other_reg;
    logic          sync_hold_mode_reg;
    logic          presc_rst_reg;
    logic          presc_rst_next;
    clock_select_t clock_select_field_reg;
    logic [2:0]    waveform_mode_field_reg;

    // Mask: only the three timer0 enables are writable, others read zero
    always_ff @(posedge CLK) begin
        if (RESET) mask_reg <= `RST_BYTE;
        else if (wr_mask) mask_reg <= req.wdata & `FLAG_WMASK;
    end

    // Timer control: clock select and waveform mode
    always_ff @(posedge CLK) begin
        if (RESET) begin
            clock_select_field_reg  <= CS_STOP;
            waveform_mode_field_reg <= 3'h0;
        end else if (wr_tctl) begin
            clock_select_field_reg  <= clock_select_t'(req.wdata[`CS_LSB +: 3]);
            waveform_mode_field_reg <= req.wdata[`WGM_LSB +: 3];
        end
    end
    assign WAVEFORM_MODE = waveform_mode_field_reg;

    // Reset bit only stays set while sync mode is on; with sync off it lasts one cycle
    always_comb begin
        presc_rst_next = presc_rst_reg & sync_hold_mode_reg;             // [R21]
        if (wr_gtc) begin
            presc_rst_next = req.wdata[`BIT_PRESC_RST];                  // [R19]
            if (!req.wdata[`BIT_SYNC_HOLD] && sync_hold_mode_reg)
                presc_rst_next = 1'b0;                                   // [R20]
        end
    end

    // General control; the other timer's bits are only stored and read back
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync_hold_mode_reg <= 1'b0;
            presc_rst_reg      <= 1'b0;
            gtc_other_reg      <= `RST_BYTE;
        end else begin
            presc_rst_reg <= presc_rst_next;
            if (wr_gtc) begin
                sync_hold_mode_reg <= req.wdata[`BIT_SYNC_HOLD];
                gtc_other_reg      <= req.wdata & `GTC_OTHER_MASK;       // [R23]
            end
        end
    end

    // =========================================================
    // Free-running prescaler, cleared only by RESET and the prescaler reset bit
    logic [`PRESC_W-1:0] presc_reg;
    logic [`PRESC_W-1:0] presc_last_reg;

    always_ff @(posedge CLK) begin
        if (RESET || presc_rst_reg) presc_reg <= '0;
        else presc_reg <= presc_reg + 1'b1;                              // [R11]
    end

    // Previous count gives one-cycle tap pulses; cleared with the count so a reset adds none
    always_ff @(posedge CLK) begin
        if (RESET || presc_rst_reg) presc_last_reg <= '0;
        else presc_last_reg <= presc_reg;
    end

    wire [`PRESC_W-1:0] tap_fall = presc_last_reg & ~presc_reg;

    // =========================================================
    // External pin
    logic ext_rise;
    logic ext_fall;

    ext_pin_sync u_ext_sync (
        .CLK   (CLK),
        .RESET (RESET),
        .PIN   (EXT_COUNT_PIN),                                          // [R13]
        .RISE  (ext_rise),
        .FALL  (ext_fall)
    );

    // =========================================================
    // Count tick selection; phase of the free prescaler gives the 1..N+1 latency
    logic tick_sel;
    always_comb begin
        case (clock_select_field_reg)
            CS_STOP:     tick_sel = 1'b0;                                // [R22]
            CS_DIRECT:   tick_sel = 1'b1;                                // [R10]
            CS_DIV8:     tick_sel = tap_fall[`TAP_8];                    // [R10] [R12]
            CS_DIV64:    tick_sel = tap_fall[`TAP_64];
            CS_DIV256:   tick_sel = tap_fall[`TAP_256];
            CS_DIV1024:  tick_sel = tap_fall[`TAP_1024];
            CS_EXT_FALL: tick_sel = ext_fall;                            // [R14] [R18]
            CS_EXT_RISE: tick_sel = ext_rise;                            // [R14] [R18]
            default:     tick_sel = 1'b0;
        endcase
    end

    // Internal-clock ticks are halted while the prescaler reset is held; external edges bypass the divider and the reset
    wire tick_ext = (clock_select_field_reg == CS_EXT_FALL) ||
                    (clock_select_field_reg == CS_EXT_RISE);
    assign COUNT_TICK = tick_sel && (tick_ext || !presc_rst_reg);        // [R15] [R19]

    // =========================================================
    // Overflow condition depends on waveform mode
    logic ovf_event;
    always_comb begin
        case (waveform_mode_field_reg)
            3'h0, 3'h2, 3'h3: ovf_event = AT_MAX;                        // [R7]
            3'h1, 3'h5:       ovf_event = AT_BOTTOM;                     // [R7]
            3'h7:             ovf_event = AT_TOP;                        // [R7]
            default:          ovf_event = 1'b0;
        endcase
    end

    // =========================================================
    // Flags: set wins over every clear in the same cycle
    irq_vec_t set_v;
    irq_vec_t clr_v;
    irq_vec_t ack_v;
    irq_vec_t flag_reg;
    irq_vec_t en_v;

    assign set_v = '{cmp_a: CMP_A_MATCH, cmp_b: CMP_B_MATCH, ovf: ovf_event}; // [R5] [R6]
    assign ack_v = '{cmp_a: CMP_A_ACK, cmp_b: CMP_B_ACK, ovf: OVF_ACK};
    assign clr_v = '{cmp_a: wr_flags & req.wdata[`BIT_CMP_A],            // [R9]
                     cmp_b: wr_flags & req.wdata[`BIT_CMP_B],
                     ovf:   wr_flags & req.wdata[`BIT_OVF]};
    assign en_v  = '{cmp_a: mask_reg[`BIT_CMP_A], cmp_b: mask_reg[`BIT_CMP_B],
                     ovf: mask_reg[`BIT_OVF]};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            always_ff @(posedge CLK) begin
                if (RESET) flag_reg[gi] <= 1'b0;
                else if (set_v[gi]) flag_reg[gi] <= 1'b1;
                else if (clr_v[gi] || ack_v[gi]) flag_reg[gi] <= 1'b0;   // [R8] [R9]
            end
        end
    endgenerate

    // Requests to the core
    assign CMP_A_IRQ = flag_reg.cmp_a & en_v.cmp_a & GLOBAL_IRQ_EN;     // [R2]
    assign CMP_B_IRQ = flag_reg.cmp_b & en_v.cmp_b & GLOBAL_IRQ_EN;     // [R1]
    assign OVF_IRQ   = flag_reg.ovf   & en_v.ovf   & GLOBAL_IRQ_EN;     // [R3]

    // =========================================================
    // Read path; reserved positions fixed at zero
    logic [7:0] flags_view;
    logic [7:0] rd_mux;
    logic [7:0] rdata_reg;

    always_comb begin
        flags_view = 8'h00;                                              // [R4]
        flags_view[`BIT_CMP_A] = flag_reg.cmp_a;
        flags_view[`BIT_CMP_B] = flag_reg.cmp_b;
        flags_view[`BIT_OVF]   = flag_reg.ovf;
    end

    always_comb begin
        case (req.addr)
            `OFS_IRQ_MASK:   rd_mux = mask_reg;
            `OFS_IRQ_FLAGS:  rd_mux = flags_view;
            `OFS_GEN_CTRL:   rd_mux = {sync_hold_mode_reg, gtc_other_reg[6:1], presc_rst_reg};
            `OFS_TMR_CTRL:   rd_mux = {1'b0, waveform_mode_field_reg, 1'b0,
                                       clock_select_field_reg};
            `OFS_TMR_STATUS: rd_mux = {6'h00, presc_rst_reg, tick_sel};
            default:         rd_mux = 8'h00;
        endcase
    end

    // Data stands for one cycle after the read strobe, zero otherwise
    always_ff @(posedge CLK) begin
        if (RESET) rdata_reg <= 8'h00;
        else rdata_reg <= req.rd ? rd_mux : 8'h00;
    end
    assign RDATA = rdata_reg;

    // =========================================================
    // Assertions
    a_irq_b_gate: assert property (@(posedge CLK) disable iff (RESET) // [R1]
        CMP_B_IRQ == (flag_reg.cmp_b && mask_reg[`BIT_CMP_B] && GLOBAL_IRQ_EN))
        else $error("compare B request wrong");
    a_irq_a_gate: assert property (@(posedge CLK) disable iff (RESET) // [R2]
        CMP_A_IRQ |-> (mask_reg[`BIT_CMP_A] && GLOBAL_IRQ_EN && flag_reg.cmp_a))
        else $error("compare A request without cause");
    a_irq_ovf_gate: assert property (@(posedge CLK) disable iff (RESET) // [R3]
        !GLOBAL_IRQ_EN |-> !OVF_IRQ)
        else $error("overflow request with global off");
    a_flag_reserved: assert property (@(posedge CLK) disable iff (RESET) // [R4]
        $past(RD) && $past(ADDR) == `OFS_IRQ_FLAGS |-> RDATA[7] == 1'b0 && RDATA[0] == 1'b0)
        else $error("reserved flag bits not zero");
    a_set_cmp_a: assert property (@(posedge CLK) disable iff (RESET) // [R5]
        CMP_A_MATCH |=> flag_reg.cmp_a)
        else $error("compare A flag not set");
    a_w1c_clear: assert property (@(posedge CLK) disable iff (RESET) // [R9]
        wr_flags && WDATA[`BIT_CMP_B] && !CMP_B_MATCH |=> !flag_reg.cmp_b)
        else $error("compare B flag not cleared");
    a_w0_keep: assert property (@(posedge CLK) disable iff (RESET) // [R9]
        flag_reg.ovf && wr_flags && !WDATA[`BIT_OVF] && !OVF_ACK |=> flag_reg.ovf)
        else $error("overflow flag lost on zero write");
    a_ack_clear: assert property (@(posedge CLK) disable iff (RESET) // [R8]
        CMP_A_ACK && !CMP_A_MATCH |=> !flag_reg.cmp_a)
        else $error("vector did not clear flag");
    a_stop_quiet: assert property (@(posedge CLK) disable iff (RESET) // [R22]
        clock_select_field_reg == CS_STOP |-> !COUNT_TICK)
        else $error("tick while stopped");
    a_rst_selfclr: assert property (@(posedge CLK) disable iff (RESET) // [R21]
        presc_rst_reg && !sync_hold_mode_reg && !wr_gtc |=> !presc_rst_reg)
        else $error("prescaler reset did not self clear");
    a_sync_hold: assert property (@(posedge CLK) disable iff (RESET) // [R19]
        presc_rst_reg && sync_hold_mode_reg && !wr_gtc |=> presc_rst_reg ##0 presc_reg == '0)
        else $error("sync mode lost reset");

    // Flag setting and clearing
    a_set_cmp_b: assert property (@(posedge CLK) disable iff (RESET) // [R6]
        CMP_B_MATCH |=> flag_reg.cmp_b)
        else $error("compare B flag not set");
    a_ovf_max: assert property (@(posedge CLK) disable iff (RESET) // [R7]
        (waveform_mode_field_reg == 3'h3) && AT_MAX |=> flag_reg.ovf)
        else $error("overflow flag missed at max");
    a_ovf_top: assert property (@(posedge CLK) disable iff (RESET) // [R7]
        (waveform_mode_field_reg == 3'h7) && AT_TOP |=> flag_reg.ovf)
        else $error("overflow flag missed at top");
    a_w1c_cmp_a: assert property (@(posedge CLK) disable iff (RESET) // [R9]
        wr_flags && WDATA[`BIT_CMP_A] && !CMP_A_MATCH |=> !flag_reg.cmp_a)
        else $error("compare A flag not cleared");
    a_w1c_ovf: assert property (@(posedge CLK) disable iff (RESET) // [R9]
        wr_flags && WDATA[`BIT_OVF] && !ovf_event |=> !flag_reg.ovf)
        else $error("overflow flag not cleared");
    a_ack_ovf: assert property (@(posedge CLK) disable iff (RESET) // [R8]
        OVF_ACK && !ovf_event |=> !flag_reg.ovf)
        else $error("overflow vector did not clear flag");
    a_ack_cmp_b: assert property (@(posedge CLK) disable iff (RESET) // [R8]
        CMP_B_ACK && !CMP_B_MATCH |=> !flag_reg.cmp_b)
        else $error("compare B vector did not clear flag");

    // Request gating
    a_irq_b_none: assert property (@(posedge CLK) disable iff (RESET) // [R1]
        !mask_reg[`BIT_CMP_B] |-> !CMP_B_IRQ)
        else $error("compare B request while masked");
    a_irq_a_none: assert property (@(posedge CLK) disable iff (RESET) // [R2]
        !GLOBAL_IRQ_EN |-> !CMP_A_IRQ)
        else $error("compare A request with global off");

    // Prescaler and count path
    a_direct_tick: assert property (@(posedge CLK) disable iff (RESET) // [R10]
        clock_select_field_reg == CS_DIRECT && !presc_rst_reg |-> COUNT_TICK)
        else $error("direct select missed a tick");
    a_tap8_phase: assert property (@(posedge CLK) disable iff (RESET) // [R10]
        clock_select_field_reg == CS_DIV8 && COUNT_TICK |-> presc_reg[2:0] == 3'h0)
        else $error("divide by 8 tick out of phase");
    a_free_run: assert property (@(posedge CLK) disable iff (RESET) // [R11]
        !presc_rst_reg |=> presc_reg == $past(presc_reg) + 1'b1)
        else $error("prescaler did not advance");
    a_presc_clear: assert property (@(posedge CLK) disable iff (RESET) // [R21]
        presc_rst_reg |=> presc_reg == '0)
        else $error("prescaler not cleared by reset bit");
    a_sync_release: assert property (@(posedge CLK) disable iff (RESET) // [R20]
        wr_gtc && !WDATA[`BIT_SYNC_HOLD] && sync_hold_mode_reg |=> !presc_rst_reg)
        else $error("leaving sync mode kept reset");

    // Pin edges as seen at two clock edges; the tick comes one or two edges later
    // depending on whether the latch caught the edge in the high or the low phase
    sequence s_pin_rise;
        !EXT_COUNT_PIN ##1 EXT_COUNT_PIN;
    endsequence
    sequence s_pin_fall;
        EXT_COUNT_PIN ##1 !EXT_COUNT_PIN;
    endsequence
    a_ext_rise: assert property (@(posedge CLK) disable iff (RESET) // [R14] [R15]
        s_pin_rise ##0 (clock_select_field_reg == CS_EXT_RISE) |-> ##[1:2] COUNT_TICK)
        else $error("rising pin edge gave no tick");
    a_ext_fall: assert property (@(posedge CLK) disable iff (RESET) // [R14] [R15]
        s_pin_fall ##0 (clock_select_field_reg == CS_EXT_FALL) |-> ##[1:2] COUNT_TICK)
        else $error("falling pin edge gave no tick");

endmodule : timer0_prescaler_irq_flags

//--- verilog/timer0_defs.svh
// Register offsets, field positions, reset values and prescaler taps for the timer0 block
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

// Register offsets (chosen)
`define OFS_IRQ_MASK      3'h0
`define OFS_IRQ_FLAGS     3'h1
`define OFS_GEN_CTRL      3'h2
`define OFS_TMR_CTRL      3'h3
`define OFS_TMR_STATUS    3'h4

// Bit positions in the mask and flag registers
`define BIT_CMP_A         4
`define BIT_CMP_B         3
`define BIT_OVF           1
`define FLAG_WMASK        8'h1A

// Bit positions in the general control register
`define BIT_SYNC_HOLD     7
`define BIT_PRESC_RST     0
`define GTC_OTHER_MASK    8'h7E

// Timer control register layout
`define CS_LSB            0
`define WGM_LSB           4

// Reset values
`define RST_BYTE          8'h00

// Prescaler taps: divisors 8, 64, 256, 1024 are bits 2, 5, 7, 9 of the count
`define PRESC_W           10
`define TAP_8             2
`define TAP_64            5
`define TAP_256           7
`define TAP_1024          9

`endif

//--- verilog/timer0_pkg.sv
// Types shared by the timer0 prescaler and flag logic
package timer0_pkg;

    typedef enum logic [2:0] {
        CS_STOP     = 3'h0,
        CS_DIRECT   = 3'h1,
        CS_DIV8     = 3'h2,
        CS_DIV64    = 3'h3,
        CS_DIV256   = 3'h4,
        CS_DIV1024  = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clock_select_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic cmp_a;
        logic cmp_b;
        logic ovf;
    } irq_vec_t;

endpackage : timer0_pkg

//--- verilog/ext_pin_sync.sv
// Synchroniser and edge detector for the external count pin
`timescale 1ns/1ps
`include "timer0_defs.svh"

module ext_pin_sync
    import timer0_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic PIN,
    output logic      RISE,
    output logic      FALL
);

    // =========================================================
    // Sampling chain
    logic latch_q;
    logic sync_reg;
    logic last_reg;

    // Latch open in the high phase gives the half-cycle; non-blocking so the flop at the
    // opening edge still takes the value held through the low phase
    always_latch begin
        if (CLK) latch_q <= PIN;
    end

    // Positive-edge registers after the latch
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync_reg <= latch_q;                    // Preload both from the pin so a high
            last_reg <= latch_q;                    // idle level gives no edge after reset
        end else begin
            sync_reg <= latch_q;
            last_reg <= sync_reg;
        end
    end

    // Edge decode on the registered pair only
    assign RISE = sync_reg & ~last_reg;
    assign FALL = ~sync_reg & last_reg;

endmodule : ext_pin_sync

//--- testbench/ext_pin_src.sv
// Far-end count source that drives the external count pin
`timescale 1ns/1ps

module ext_pin_src (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output logic            pin,
    output logic [7:0]      rises,
    output logic [7:0]      falls
);
    logic [3:0] cnt_reg;

    initial begin
        pin = 1'b0;
        rises = 8'h00;
        falls = 8'h00;
        cnt_reg = 4'h0;
    end

    // =========================================================
    // Pin toggling
    // Idle pin never moves, so enabling the input sees no edge
    always @(posedge clk) begin
        if (run && cnt_reg + 4'h1 >= half && half >= 4'h2) begin
            cnt_reg <= 4'h0;
            pin <= ~pin;
            rises <= rises + {7'h00, ~pin};
            falls <= falls + {7'h00, pin};
        end else if (run) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule : ext_pin_src

//--- testbench/tb_top.sv
// Self-checking bench for the timer0 prescaler and flag block
`timescale 1ns/1ps
`include "timer0_defs.svh"

module tb_top;
    logic       CLK = 1'b0;
    logic       RESET = 1'b1;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic       WR = 1'b0;
    logic       RD = 1'b0;
    logic       GLOBAL_IRQ_EN = 1'b0;
    logic [7:0] ev = 8'h00;
    logic       run = 1'b0;
    logic [7:0] RDATA, rises, falls;
    logic       COUNT_TICK, CMP_A_IRQ, CMP_B_IRQ, OVF_IRQ, pin;
    logic [2:0] WAVEFORM_MODE;
    int         fail_count = 0;
    int         tests_run = 0;

    always #10 CLK = ~CLK;

    timer0_prescaler_irq_flags u_timer0_prescaler_irq_flags (
        .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .CMP_A_MATCH(ev[7]),
        .CMP_B_MATCH(ev[6]), .AT_MAX(ev[5]), .AT_TOP(ev[4]), .AT_BOTTOM(ev[3]),
        .CMP_A_ACK(ev[2]), .CMP_B_ACK(ev[1]), .OVF_ACK(ev[0]),
        .EXT_COUNT_PIN(pin), .COUNT_TICK(COUNT_TICK), .WAVEFORM_MODE(WAVEFORM_MODE),
        .CMP_A_IRQ(CMP_A_IRQ), .CMP_B_IRQ(CMP_B_IRQ), .OVF_IRQ(OVF_IRQ));

    ext_pin_src u_ext_pin_src (.clk(CLK), .run(run), .half(4'h3), .pin(pin),
        .rises(rises), .falls(falls));

    // =========================================================
    // Shared tasks
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(n, {8'h00, e}, {8'h00, RDATA});
    endtask : rd

    task automatic pulse(input logic [7:0] v);
        @(posedge CLK);
        ev <= v;
        @(posedge CLK);
        ev <= 8'h00;
    endtask : pulse

    task automatic cnt(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge CLK);
            #1;
            c += int'(COUNT_TICK === 1'b1);
        end
    endtask : cnt

    // Cycles until the next tick, bounded so a dead tap cannot hang
    task automatic gap(input int lim, output int c);
        c = 0;
        do begin
            @(posedge CLK);
            #1;
            c++;
        end while (COUNT_TICK !== 1'b1 && c <= lim);
    endtask : gap

    function automatic logic [15:0] irq();
        return {13'h0, CMP_A_IRQ, CMP_B_IRQ, OVF_IRQ};
    endfunction : irq

    // Event index: 0 max, 1 top, 2 bottom
    function automatic bit ovf_exp(input int m, input int e);
        case (m)
            0, 2, 3: return e == 0;
            1, 5: return e == 2;
            7: return e == 1;
            default: return 0;
        endcase
    endfunction : ovf_exp

    // =========================================================
    // Scenarios
    task automatic t_flags();
        rd(`OFS_IRQ_FLAGS, 8'h00, "flags rst");
        rd(3'h7, 8'h00, "unmapped");
        wr(`OFS_IRQ_MASK, 8'hFF);
        rd(`OFS_IRQ_MASK, 8'h1A, "mask");
        wr(`OFS_IRQ_FLAGS, 8'hFF);
        rd(`OFS_IRQ_FLAGS, 8'h00, "flags w1");
        pulse(8'hE0);
        rd(`OFS_IRQ_FLAGS, 8'h1A, "flags set");
        chk("irq off", 16'h0, irq());
        @(posedge CLK);
        GLOBAL_IRQ_EN <= 1'b1;
        @(posedge CLK);
        #1;
        chk("irq on", 16'h7, irq());
        wr(`OFS_IRQ_MASK, 8'h10);
        #1;
        chk("irq a", 16'h4, irq());
        wr(`OFS_IRQ_FLAGS, 8'h10);
        rd(`OFS_IRQ_FLAGS, 8'h0A, "w1c");
        pulse(8'h02);
        rd(`OFS_IRQ_FLAGS, 8'h02, "ack b");
        pulse(8'h01);
        pulse(8'h80);
        pulse(8'h04);
        rd(`OFS_IRQ_FLAGS, 8'h00, "ack a ovf");
        @(posedge CLK);
        GLOBAL_IRQ_EN <= 1'b0;
    endtask : t_flags

    task automatic t_ovf();
        for (int m = 0; m < 8; m++) begin
            for (int e = 0; e < 3; e++) begin
                wr(`OFS_TMR_CTRL, 8'(m << 4));
                #1;
                chk("mode", 16'(m), {13'h0, WAVEFORM_MODE});
                pulse(8'h20 >> e);
                rd(`OFS_IRQ_FLAGS, ovf_exp(m, e) ? 8'h02 : 8'h00, "ovf");
                wr(`OFS_IRQ_FLAGS, 8'h02);
            end
        end
    endtask : t_ovf

    task automatic t_presc();
        int c;
        int div[4] = '{8, 64, 256, 1024};
        wr(`OFS_TMR_CTRL, 8'h00);
        cnt(30, c);
        chk("stop", 16'h0, 16'(c));
        wr(`OFS_TMR_CTRL, 8'h01);
        cnt(5, c);
        chk("direct", 16'h5, 16'(c));
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_TMR_CTRL, 8'(i + 2));
            gap(div[i] + 1, c);
            chk("first", 16'h1, 16'(c <= div[i] + 1));
            gap(div[i], c);
            chk("period", 16'(div[i]), 16'(c));
        end
        // Switching taps must not disturb the free count
        wr(`OFS_TMR_CTRL, 8'h02);
        gap(9, c);
        chk("phase", 16'h8, 16'(c + 2));
    endtask : t_presc

    task automatic t_sync();
        int c;
        wr(`OFS_GEN_CTRL, 8'h81);
        cnt(30, c);
        chk("held", 16'h0, 16'(c));
        rd(`OFS_GEN_CTRL, 8'h81, "hold rd");
        rd(`OFS_TMR_STATUS, 8'h02, "status");
        wr(`OFS_GEN_CTRL, 8'h00);
        rd(`OFS_GEN_CTRL, 8'h00, "release");
        gap(9, c);
        chk("resume", 16'h1, 16'(c <= 9));
        wr(`OFS_GEN_CTRL, 8'h01);
        rd(`OFS_GEN_CTRL, 8'h00, "self clr");
        wr(`OFS_GEN_CTRL, 8'h7E);
        rd(`OFS_GEN_CTRL, 8'h7E, "other");
        gap(9, c);
        chk("other run", 16'h1, 16'(c <= 9));
        wr(`OFS_GEN_CTRL, 8'h00);
    endtask : t_sync

    // Each detected edge gives one undivided tick
    task automatic t_ext(input logic [7:0] sel);
        int c1;
        int c2;
        logic [7:0] r0;
        logic [7:0] f0;
        wr(`OFS_TMR_CTRL, sel);
        repeat (2) @(posedge CLK);
        r0 = rises;
        f0 = falls;
        run <= 1'b1;
        cnt(60, c1);
        run <= 1'b0;
        cnt(8, c2);
        chk("edges", 16'(sel[0] ? rises - r0 : falls - f0), 16'(c1 + c2));
    endtask : t_ext

    // =========================================================
    // Closing and main sequence
    task automatic test_done();
        $display("tests %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        t_flags();
        t_ovf();
        t_presc();
        t_sync();
        t_ext(8'h07);
        t_ext(8'h06);
        test_done();
    end

    // Whole run needs about 2300 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        test_done();
    end
endmodule : tb_top
